// file: rtl/pdfs_consts.svh
// constants for the port d pin function select block
`ifndef PDFS_CONSTS_SVH
`define PDFS_CONSTS_SVH
`define PDFS_OFS_HI 4'h0
`define PDFS_OFS_LO 4'h4
`define PDFS_OFS_STAT 4'h8
`define PDFS_REG_W 16
`define PDFS_RST_HI 16'h0000
`define PDFS_RST_LO 16'h0000
`define PDFS_CODE_GPIO 2'h0
`define PDFS_CODE_DATA 2'h1
`define PDFS_CODE_IRQ 2'h2
`define PDFS_CODE_RSVD 2'h3
`define PDFS_HTRANS_NONSEQ 2'h2
`define PDFS_NUM_HI 8
`define PDFS_NUM_LO 16
`endif

// file: rtl/pdfs_pkg.sv
// types for the port d pin function select block
package pdfs_pkg;
  typedef enum logic [1:0] {
    PDFS_MODE_SINGLE,
    PDFS_MODE_EXT_ROM,
    PDFS_MODE_EXT_NOROM
  } pdfs_mode_t;

  typedef enum logic [1:0] {
    PDFS_FN_GPIO,
    PDFS_FN_DATA,
    PDFS_FN_IRQ,
    PDFS_FN_RSVD
  } pdfs_fn_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic valid;
  } pdfs_req_t;

  typedef struct packed {
    logic [23:0] gpio_oe;
    logic [23:0] gpio_o;
    logic [23:0] data_oe;
    logic [23:0] data_o;
  } pdfs_drive_t;
endpackage : pdfs_pkg

// file: rtl/pdfs_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module pdfs_sync #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : pdfs_sync

// file: rtl/pdfs_hi_decode.sv
// decode of one upper port d pin field into its effective function
`timescale 1ns/100ps
`include "pdfs_consts.svh"
module pdfs_hi_decode (
  // setting
  input wire logic [1:0] code_in,
  input wire pdfs_pkg::pdfs_mode_t mode_in,
  input wire logic cs0_wide_in,
  // result
  output pdfs_pkg::pdfs_fn_t fn_out
);
  always_comb begin
    fn_out = pdfs_pkg::PDFS_FN_GPIO;
    case (code_in)
      `PDFS_CODE_GPIO: begin
        // romless with a 24-bit area zero needs the upper data lanes
        if (mode_in == pdfs_pkg::PDFS_MODE_EXT_NOROM && cs0_wide_in) begin
          fn_out = pdfs_pkg::PDFS_FN_DATA;
        end
      end
      `PDFS_CODE_DATA: begin
        if (mode_in != pdfs_pkg::PDFS_MODE_SINGLE) begin
          fn_out = pdfs_pkg::PDFS_FN_DATA;
        end
      end
      `PDFS_CODE_IRQ: begin
        fn_out = pdfs_pkg::PDFS_FN_IRQ;
      end
      default: begin
        // reserved code: treated as a safe input-only state
        fn_out = pdfs_pkg::PDFS_FN_RSVD;
      end
    endcase
  end
endmodule : pdfs_hi_decode

// file: rtl/pdfs_top.sv
// port d pin function multiplexer with ahb-lite register slave
// Overview of operation
// - bits 15:14 select pin 23 function
// - bits 13:12 select pin 22 function
// - bits 11:10 select pin 21 function
// - bits 9:8 select pin 20 function
// - bits 7:6 select pin 19 function
// - bits 5:4 select pin 18 function
// - bits 3:2 select pin 17 function
// - bits 1:0 select pin 16 function
// - code 00 is data when romless wide
// - single-chip turns code 01 into gpio
// - low register is 16-bit read/write
// - romless extended forces low pins to data
// - rom extended honours low register
// - single-chip forces low pins to gpio
// - low register cleared only by power-on
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "pdfs_consts.svh"
module pdfs_top (
  // clock and resets
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic por_n_in,
  // operating mode straps
  input wire logic mode_ext_in,
  input wire logic rom_en_in,
  input wire logic cs0_wide_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // port logic side
  input wire logic [23:0] gpio_o_in,
  input wire logic [23:0] gpio_oe_in,
  input wire logic [23:0] bus_data_o_in,
  input wire logic bus_data_oe_in,
  output logic [23:0] gpio_i_out,
  output logic [23:0] bus_data_i_out,
  output logic [7:0] ext_interrupt_out,
  // pins
  input wire logic [23:0] pd_pin_i_in,
  output logic [23:0] pd_pin_o_out,
  output logic [23:0] pd_pin_oe_out
);
  logic [`PDFS_REG_W-1:0] port_d_pins16_23_function_select_q;
  logic [`PDFS_REG_W-1:0] port_d_pins0_15_function_select_q;
  pdfs_pkg::pdfs_req_t req_q;
  pdfs_pkg::pdfs_mode_t mode;
  pdfs_pkg::pdfs_drive_t drv;
  pdfs_pkg::pdfs_fn_t fn_hi [`PDFS_NUM_HI];
  logic [23:0] pin_sync;
  logic [23:0] is_data;
  logic [23:0] is_gpio;
  logic [7:0] is_irq;
  logic [23:0] pin_o_d;
  logic [23:0] pin_oe_d;
  logic [23:0] pin_o_q;
  logic [23:0] pin_oe_q;
  logic [7:0] irq_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [31:0] wdata_word;
  logic rsvd_seen_q;

  // mode from straps
  always_comb begin
    if (!mode_ext_in) begin
      mode = pdfs_pkg::PDFS_MODE_SINGLE;
    end else if (rom_en_in) begin
      mode = pdfs_pkg::PDFS_MODE_EXT_ROM;
    end else begin
      mode = pdfs_pkg::PDFS_MODE_EXT_NOROM;
    end
  end

  // bus address phase capture
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      req_q <= '0;
    end else if (hready_in) begin
      req_q.valid <= hsel_in && htrans_in == `PDFS_HTRANS_NONSEQ;
      req_q.write <= hwrite_in;
      req_q.addr <= haddr_in;
    end
  end

  assign wdata_word = hwdata_in;

  // upper register follows the ordinary system reset
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      port_d_pins16_23_function_select_q <= `PDFS_RST_HI;
    end else if (req_q.valid && req_q.write && req_q.addr[3:0] == `PDFS_OFS_HI) begin
      port_d_pins16_23_function_select_q <= wdata_word[`PDFS_REG_W-1:0];
    end
  end

  // low register keeps its value through manual and watchdog resets
  always_ff @(posedge ref_clk_in) begin
    if (!por_n_in) begin
      port_d_pins0_15_function_select_q <= `PDFS_RST_LO;
    end else if (rstn_in && req_q.valid && req_q.write
                 && req_q.addr[3:0] == `PDFS_OFS_LO) begin
      port_d_pins0_15_function_select_q <= wdata_word[`PDFS_REG_W-1:0];
    end
  end

  // sticky record of a reserved code written, readable for debug
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rsvd_seen_q <= 1'b0;
    end else if (is_rsvd_any()) begin
      rsvd_seen_q <= 1'b1;
    end
  end

  function automatic logic is_rsvd_any();
    logic r;
    r = 1'b0;
    for (int k = 0; k < `PDFS_NUM_HI; k++) begin
      r = r | (fn_hi[k] == pdfs_pkg::PDFS_FN_RSVD);
    end
    return r;
  endfunction : is_rsvd_any

  // read mux
  always_comb begin
    rdata_d = '0;
    if (req_q.valid && !req_q.write) begin
      case (req_q.addr[3:0])
        `PDFS_OFS_HI: rdata_d = {16'h0000, port_d_pins16_23_function_select_q};
        `PDFS_OFS_LO: rdata_d = {16'h0000, port_d_pins0_15_function_select_q};
        `PDFS_OFS_STAT: rdata_d = {29'h00000000, rsvd_seen_q, mode};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // zero-wait slave: data phase is the cycle after the address phase
  assign hrdata_out = rdata_d;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  pdfs_sync #(
    .W(24)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in(pd_pin_i_in),
    .sync_out(pin_sync)
  );

  // per-pin function for the upper eight pins
  genvar g;
  generate
    for (g = 0; g < `PDFS_NUM_HI; g++) begin : g_hi
      pdfs_hi_decode u_dec (
        .code_in(port_d_pins16_23_function_select_q[2*g+1:2*g]),
        .mode_in(mode),
        .cs0_wide_in(cs0_wide_in),
        .fn_out(fn_hi[g])
      );
      assign is_data[16+g] = fn_hi[g] == pdfs_pkg::PDFS_FN_DATA;
      assign is_irq[g] = fn_hi[g] == pdfs_pkg::PDFS_FN_IRQ;
      assign is_gpio[16+g] = fn_hi[g] == pdfs_pkg::PDFS_FN_GPIO;
    end
    for (g = 0; g < `PDFS_NUM_LO; g++) begin : g_lo
      always_comb begin
        case (mode)
          pdfs_pkg::PDFS_MODE_EXT_NOROM: is_data[g] = 1'b1;
          pdfs_pkg::PDFS_MODE_EXT_ROM: is_data[g] = port_d_pins0_15_function_select_q[g];
          default: is_data[g] = 1'b0;
        endcase
      end
      assign is_gpio[g] = !is_data[g];
    end
  endgenerate

  // pin drive selection; irq and reserved pins are input only
  always_comb begin
    drv.gpio_oe = gpio_oe_in & is_gpio;
    drv.gpio_o = gpio_o_in & is_gpio;
    drv.data_oe = {24{bus_data_oe_in}} & is_data;
    drv.data_o = bus_data_o_in & is_data;
    pin_oe_d = drv.gpio_oe | drv.data_oe;
    pin_o_d = (drv.gpio_o & drv.gpio_oe) | (drv.data_o & drv.data_oe);
  end

  // registered pin drive and interrupt forwarding
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
      irq_q <= '0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      irq_q <= pin_sync[23:16] & is_irq;
    end
  end

  assign pd_pin_o_out = pin_o_q;
  assign pd_pin_oe_out = pin_oe_q;
  assign ext_interrupt_out = irq_q;
  assign gpio_i_out = pin_sync & is_gpio;
  assign bus_data_i_out = pin_sync & is_data;

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  irq_oe_off_a: assert property (is_irq[7] |=> !pd_pin_oe_out[23] || !$past(is_irq[7]))
    else $error("irq pin driven");
  norom_data_a: assert property (mode == pdfs_pkg::PDFS_MODE_EXT_NOROM |-> &is_data[15:0])
    else $error("low pins not data");
  single_gpio_a: assert property (mode == pdfs_pkg::PDFS_MODE_SINGLE |-> is_data == 24'h000000)
    else $error("data in single chip");
  rom_low_a: assert property (mode == pdfs_pkg::PDFS_MODE_EXT_ROM
                              |-> is_data[15:0] == port_d_pins0_15_function_select_q)
    else $error("low reg ignored");
  wide_zero_a: assert property (mode == pdfs_pkg::PDFS_MODE_EXT_NOROM && cs0_wide_in
      && port_d_pins16_23_function_select_q[1:0] == `PDFS_CODE_GPIO |-> is_data[16])
    else $error("code 00 not data");
  irq_fwd_a: assert property (is_irq[0] && $stable(is_irq[0]) |=> ext_interrupt_out[0]
      == $past(pin_sync[16]))
    else $error("irq not forwarded");
  hi_write_a: assert property (req_q.valid && req_q.write && req_q.addr[3:0] == `PDFS_OFS_HI
      |=> port_d_pins16_23_function_select_q == $past(hwdata_in[15:0]))
    else $error("hi write lost");
  irq23_a: assert property (port_d_pins16_23_function_select_q[15:14] == `PDFS_CODE_IRQ
      |-> is_irq[7] && !is_data[23])
    else $error("pin 23 irq");
  lo_hold_a: assert property (@(posedge ref_clk_in) disable iff (!por_n_in)
      !rstn_in |=> $stable(port_d_pins0_15_function_select_q))
    else $error("low reg lost");

  wr_lo_c: cover property (req_q.valid && req_q.write && req_q.addr[3:0] == `PDFS_OFS_LO);
  irq_sel_c: cover property (is_irq != 8'h00);
  norom_c: cover property (mode == pdfs_pkg::PDFS_MODE_EXT_NOROM);
  single_c: cover property (mode == pdfs_pkg::PDFS_MODE_SINGLE);
endmodule : pdfs_top

// file: verification/pdfs_tb.sv
// self-checking bench for the port d pin function select block
`timescale 1ns/100ps
module tb;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic por_n_in = 1'b0;
  logic mode_ext_in = 1'b0;
  logic rom_en_in = 1'b1;
  logic cs0_wide_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic [23:0] gpio_o_in = 24'h5a3c96;
  logic [23:0] gpio_oe_in = 24'hc3f0a5;
  logic [23:0] bus_data_o_in = 24'h96e1d2;
  logic bus_data_oe_in = 1'b1;
  logic [23:0] pd_pin_i_in = 24'h9b6e35;
  logic [31:0] hrdata_out;
  logic hreadyout_out, hresp_out;
  logic [23:0] gpio_i_out, bus_data_i_out, pd_pin_o_out, pd_pin_oe_out;
  logic [7:0] ext_interrupt_out;
  logic [31:0] rd_smp;
  int error_cnt = 0;
  int n_checks = 0;
  // mixed patterns catch swapped or shifted fields
  logic [15:0] hi_p [5] = '{16'h5555, 16'haaaa, 16'h0000, 16'h2491, 16'h9864};
  logic [15:0] lo_p [5] = '{16'ha5c3, 16'h3c5a, 16'hffff, 16'h0000, 16'h6a95};

  always #25 ref_clk_in = ~ref_clk_in;

  // read data as it stood just before the edge that closes the data phase
  always @(posedge ref_clk_in) begin
    rd_smp <= hrdata_out;
  end

  pdfs_top DUT (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .por_n_in(por_n_in),
    .mode_ext_in(mode_ext_in), .rom_en_in(rom_en_in), .cs0_wide_in(cs0_wide_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .gpio_o_in(gpio_o_in), .gpio_oe_in(gpio_oe_in), .bus_data_o_in(bus_data_o_in),
    .bus_data_oe_in(bus_data_oe_in), .gpio_i_out(gpio_i_out),
    .bus_data_i_out(bus_data_i_out), .ext_interrupt_out(ext_interrupt_out),
    .pd_pin_i_in(pd_pin_i_in), .pd_pin_o_out(pd_pin_o_out), .pd_pin_oe_out(pd_pin_oe_out)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_rdy();
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk_in);
      if (hreadyout_out === 1'b1) return;
    end
    chk("bus timeout", 32'h1, 32'h0);
    conclude();
  endtask : wait_rdy

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    wait_rdy();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_rdy();
    // hrdata is combinational from the captured address, so take the pre-edge copy
    #1;
    rd = rd_smp;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(a, 1'b1, d, rd);
  endtask : wr

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(a, 1'b0, 32'h0, rd);
    chk(nm, exp, rd);
  endtask : rdc

  // m: 0 single chip, 1 extended with rom, 2 romless narrow, 3 romless wide
  task automatic pins(input int m, input logic [15:0] hi, input logic [15:0] lo);
    logic [23:0] eoe, eo, egi, edi;
    logic [7:0] eirq;
    logic [1:0] c;
    int f;
    {eoe, eo, egi, edi, eirq} = '0;
    for (int k = 0; k < 24; k++) begin
      c = hi[2*(k%16) +: 2];
      if (k < 16) f = (m == 0) ? 0 : (m == 1) ? (lo[k] ? 1 : 0) : 1;
      else f = (c == 2'h2) ? 2 : (c == 2'h1) ? ((m == 0) ? 0 : 1) : ((m == 3) ? 1 : 0);
      if (f == 0) begin
        eoe[k] = gpio_oe_in[k];
        eo[k] = gpio_o_in[k];
        egi[k] = pd_pin_i_in[k];
      end else if (f == 1) begin
        eoe[k] = bus_data_oe_in;
        eo[k] = bus_data_o_in[k];
        edi[k] = pd_pin_i_in[k];
      end else begin
        eirq[k-16] = pd_pin_i_in[k];
      end
    end
    chk("pin oe", {8'h0, eoe}, {8'h0, pd_pin_oe_out});
    chk("pin out", {8'h0, eo & eoe}, {8'h0, pd_pin_o_out & pd_pin_oe_out});
    chk("gpio in", {8'h0, egi}, {8'h0, gpio_i_out});
    chk("bus in", {8'h0, edi}, {8'h0, bus_data_i_out});
    chk("irq", {24'h0, eirq}, {24'h0, ext_interrupt_out});
  endtask : pins

  initial begin
    logic [31:0] rd;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    por_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rdc("hi reset", 32'h0, 32'h0);
    rdc("lo reset", 32'h4, 32'h0);
    wr(32'h4, 32'hffffffff);
    rdc("lo width", 32'h4, 32'h0000ffff);
    wr(32'hc, 32'h00001234);
    rdc("unmapped", 32'hc, 32'h0);
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 5; p++) begin
        mode_ext_in <= (m != 0);
        rom_en_in <= (m == 1);
        cs0_wide_in <= (m != 2);
        wr(32'h0, {16'h0, hi_p[p]});
        wr(32'h4, {16'h0, lo_p[p]});
        // irq path is three cycles from the pin, so four covers every output
        repeat (4) @(posedge ref_clk_in);
        pins(m, hi_p[p], lo_p[p]);
        rdc("hi", 32'h0, {16'h0, hi_p[p]});
        rdc("status", 32'h8, {30'h0, (m == 0) ? 2'h0 : (m == 1) ? 2'h1 : 2'h2});
      end
    end
    wr(32'h0, 32'h0000c000);
    repeat (4) @(posedge ref_clk_in);
    chk("rsvd oe", 32'h0, {31'h0, pd_pin_oe_out[23]});
    chk("rsvd irq", 32'h0, {31'h0, ext_interrupt_out[7]});
    bus(32'h8, 1'b0, 32'h0, rd);
    chk("rsvd seen", 32'h4, rd & 32'h4);
    wr(32'h4, 32'h00007e81);
    rstn_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    rdc("lo kept", 32'h4, 32'h00007e81);
    rdc("hi cleared", 32'h0, 32'h0);
    rdc("status cleared", 32'h8, 32'h2);
    por_n_in <= 1'b0;
    @(posedge ref_clk_in);
    por_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rdc("lo por", 32'h4, 32'h0);
    conclude();
  end
endmodule : tb
